// ===== core/stc_pkg.sv
// package of constants shared by both ends of the task-file link
// assumes a single pclk domain and an 8-bit task-file register set
package stc_pkg;

   // ****************************************
   // task-file register addresses
   // ****************************************
   localparam logic [2:0] TF_FEATURE = 3'h1;
   localparam logic [2:0] TF_SCOUNT  = 3'h2;
   localparam logic [2:0] TF_SNUM    = 3'h3;
   localparam logic [2:0] TF_CYL_LO  = 3'h4;
   localparam logic [2:0] TF_CYL_HI  = 3'h5;
   localparam logic [2:0] TF_DEVHEAD = 3'h6;
   localparam logic [2:0] TF_COMMAND = 3'h7;

   // ****************************************
   // opcodes and fields
   // ****************************************
   localparam logic [3:0] OP_SEEK_NIB  = 4'h7;
   localparam logic [7:0] OP_SENSE     = 8'hf0;
   localparam logic [7:0] SENSE_FEAT   = 8'h01;
   localparam int         DH_LBA_BIT   = 6;
   localparam logic [7:0] DH_FIXED     = 8'ha0;

   // ****************************************
   // status and error bits
   // ****************************************
   localparam int ST_BSY  = 7;
   localparam int ST_RDY  = 6;
   localparam int ST_DSC  = 4;
   localparam int ST_ERR  = 0;
   localparam int ER_IDN  = 4;
   localparam int ER_ABT  = 2;
   localparam logic [7:0] ST_RESET = 8'h50;

   // ****************************************
   // temperature coding, half-degree units
   // ****************************************
   localparam logic signed [9:0] TEMP_LOW_HALF  = -10'sd40;
   localparam logic signed [9:0] TEMP_HIGH_HALF = 10'sd214;
   localparam logic signed [9:0] TEMP_OFFSET    = 10'sd40;
   localparam logic [7:0]        TEMP_CODE_LOW  = 8'h00;
   localparam logic [7:0]        TEMP_CODE_HIGH = 8'hff;

   // ****************************************
   // controller apb map
   // ****************************************
   localparam logic [7:0] A_CTRL    = 8'h00;
   localparam logic [7:0] A_TF_ADDR = 8'h04;
   localparam logic [7:0] A_TF_CMD  = 8'h08;
   localparam logic [7:0] A_STATE   = 8'h0c;
   localparam logic [7:0] A_RESULT  = 8'h10;
   localparam logic [7:0] A_RES_SC  = 8'h14;
   localparam logic [7:0] A_IRQ_ST  = 8'h18;
   localparam logic [7:0] A_IRQ_MSK = 8'h1c;
   localparam int         IRQ_DONE  = 0;
   localparam int         IRQ_FAIL  = 1;
   localparam int         IRQ_W     = 2;

   typedef enum logic [1:0] {DEV_IDLE, DEV_EXEC, DEV_SEEK} stc_dev_state_t;
   typedef enum logic [1:0] {HST_IDLE, HST_SEND, HST_WAIT} stc_hst_state_t;

endpackage

// ===== core/stc_taskfile_if.sv
// task-file link between the host controller and the drive command logic
// assumes both ends share pclk; device registers are always visible
`timescale 1ns/1ps
`default_nettype none
interface stc_taskfile_if;
   logic       tf_wr;
   logic [2:0] tf_addr;
   logic [7:0] tf_wdata;
   logic [7:0] rd_error;
   logic [7:0] rd_scount;
   logic [7:0] rd_snum;
   logic [7:0] rd_cyl_lo;
   logic [7:0] rd_cyl_hi;
   logic [7:0] rd_devhead;
   logic [7:0] rd_status;

   modport dev (input tf_wr, tf_addr, tf_wdata,
                output rd_error, rd_scount, rd_snum, rd_cyl_lo, rd_cyl_hi,
                rd_devhead, rd_status);
   modport host (output tf_wr, tf_addr, tf_wdata,
                 input rd_error, rd_scount, rd_snum, rd_cyl_lo, rd_cyl_hi,
                 rd_devhead, rd_status);
endinterface
`default_nettype wire

// ===== core/stc_drive_cmd.sv
// drive-side command logic for seek and temperature sense
// assumes host writes task-file registers only while not busy (writes while busy are dropped) and reads them back any time
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module stc_drive_cmd
   import stc_pkg::*;
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   stc_taskfile_if.dev            tf,
   input  wire logic              standby,
   input  wire logic signed [9:0] temp_half_c,
   output logic                   seek_req,
   output logic                   seek_lba_mode,
   output logic [15:0]            seek_cyl,
   output logic [3:0]             seek_head,
   output logic [27:0]            seek_lba,
   input  wire logic              seek_done,
   input  wire logic              seek_idnf,
   input  wire logic              seek_abort
);

   // ****************************************
   // task-file storage
   // ****************************************
   logic [7:0]     feature_reg;
   logic [7:0]     command_reg;
   logic [7:0]     scount_reg;
   logic [7:0]     snum_reg;
   logic [7:0]     cyl_lo_reg;
   logic [7:0]     cyl_hi_reg;
   logic [7:0]     devhead_reg;
   logic [7:0]     error_reg;
   logic [7:0]     status_reg;
   stc_dev_state_t state_reg;
   logic [7:0]     temp_code;
   logic           host_wr;
   logic           busy;

   assign busy    = status_reg[ST_BSY];
   assign host_wr = tf.tf_wr && !busy;

   // temperature to result code
   always_comb begin
      if (temp_half_c <= TEMP_LOW_HALF) begin
         temp_code = TEMP_CODE_LOW;
      end else if (temp_half_c > TEMP_HIGH_HALF) begin
         temp_code = TEMP_CODE_HIGH;
      end else begin
         temp_code = 8'(temp_half_c + TEMP_OFFSET);
      end
   end

   // ****************************************
   // command sequencer
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= DEV_IDLE;
      end else begin
         case (state_reg)
            DEV_IDLE: begin
               if (host_wr && tf.tf_addr == TF_COMMAND) begin
                  state_reg <= DEV_EXEC;
               end
            end
            DEV_EXEC: begin
               if (command_reg[7:4] == OP_SEEK_NIB) begin
                  state_reg <= DEV_SEEK;
               end else begin
                  state_reg <= DEV_IDLE;
               end
            end
            DEV_SEEK: begin
               if (seek_done) begin
                  state_reg <= DEV_IDLE;
               end
            end
            default: state_reg <= DEV_IDLE;
         endcase
      end
   end

   // ****************************************
   // actuator request, no format check
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seek_req      <= 1'b0;
         seek_lba_mode <= 1'b0;
         seek_cyl      <= 16'h0000;
         seek_head     <= 4'h0;
         seek_lba      <= 28'h0000000;
      end else begin
         seek_req <= state_reg == DEV_EXEC && command_reg[7:4] == OP_SEEK_NIB;
         if (state_reg == DEV_EXEC) begin
            seek_lba_mode <= devhead_reg[DH_LBA_BIT];
            seek_cyl      <= {cyl_hi_reg, cyl_lo_reg};
            seek_head     <= devhead_reg[3:0];
            seek_lba      <= {devhead_reg[3:0], cyl_hi_reg, cyl_lo_reg, snum_reg};
         end
      end
   end

   // ****************************************
   // task-file registers and results
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         feature_reg <= 8'h00;
         command_reg <= 8'h00;
         scount_reg  <= 8'h00;
         snum_reg    <= 8'h00;
         cyl_lo_reg  <= 8'h00;
         cyl_hi_reg  <= 8'h00;
         devhead_reg <= DH_FIXED;
         error_reg   <= 8'h00;
         status_reg  <= ST_RESET;
      end else if (host_wr) begin
         if (tf.tf_addr == TF_FEATURE) begin
            feature_reg <= tf.tf_wdata;
         end else if (tf.tf_addr == TF_SCOUNT) begin
            scount_reg <= tf.tf_wdata;
         end else if (tf.tf_addr == TF_SNUM) begin
            snum_reg <= tf.tf_wdata;
         end else if (tf.tf_addr == TF_CYL_LO) begin
            cyl_lo_reg <= tf.tf_wdata;
         end else if (tf.tf_addr == TF_CYL_HI) begin
            cyl_hi_reg <= tf.tf_wdata;
         end else if (tf.tf_addr == TF_DEVHEAD) begin
            devhead_reg <= tf.tf_wdata;
         end else if (tf.tf_addr == TF_COMMAND) begin
            command_reg <= tf.tf_wdata;
            error_reg   <= 8'h00;
            status_reg  <= 8'h00;
            status_reg[ST_BSY] <= 1'b1;
         end
      end else if (state_reg == DEV_EXEC) begin
         if (command_reg == OP_SENSE) begin
            // sense ignores standby on purpose
            status_reg <= 8'h00;
            status_reg[ST_RDY] <= !standby || 1'b1;
            status_reg[ST_DSC] <= 1'b1;
            if (feature_reg != SENSE_FEAT) begin
               error_reg[ER_ABT]  <= 1'b1;
               status_reg[ST_ERR] <= 1'b1;
            end else begin
               scount_reg <= temp_code;
            end
         end else if (command_reg[7:4] != OP_SEEK_NIB) begin
            status_reg <= 8'h00;
            status_reg[ST_RDY] <= 1'b1;
            status_reg[ST_DSC] <= 1'b1;
            status_reg[ST_ERR] <= 1'b1;
            error_reg[ER_ABT]  <= 1'b1;
         end
      end else if (state_reg == DEV_SEEK && seek_done) begin
         status_reg <= 8'h00;
         status_reg[ST_RDY] <= 1'b1;
         status_reg[ST_DSC] <= 1'b1;
         if (seek_idnf || seek_abort) begin
            status_reg[ST_ERR] <= 1'b1;
            error_reg <= 8'h00;
            error_reg[ER_IDN] <= seek_idnf;
            error_reg[ER_ABT] <= !seek_idnf;
         end else if (seek_lba_mode) begin
            snum_reg    <= seek_lba[7:0];
            cyl_lo_reg  <= seek_lba[15:8];
            cyl_hi_reg  <= seek_lba[23:16];
            devhead_reg <= {devhead_reg[7:4], seek_lba[27:24]};
         end
      end
   end

   // ****************************************
   // read-back to the host
   // ****************************************
   assign tf.rd_error   = error_reg;
   assign tf.rd_scount  = scount_reg;
   assign tf.rd_snum    = snum_reg;
   assign tf.rd_cyl_lo  = cyl_lo_reg;
   assign tf.rd_cyl_hi  = cyl_hi_reg;
   assign tf.rd_devhead = devhead_reg;
   assign tf.rd_status  = status_reg;

endmodule
`default_nettype wire

// ===== core/stc_host_ctrl.sv
// host controller: apb registers drive one task-file command at a time
// assumes apb master on pclk and the drive end on the same clock
`timescale 1ns/1ps
`default_nettype none
module stc_host_ctrl
   import stc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   stc_taskfile_if.host     tf
);

   // ****************************************
   // controller registers
   // ****************************************
   logic [31:0]      tf_addr_reg;
   logic [23:0]      tf_cmd_reg;
   logic [31:0]      result_reg;
   logic [7:0]       res_sc_reg;
   logic [15:0]      res_ef_reg;
   logic [IRQ_W-1:0] irq_st_reg;
   logic [IRQ_W-1:0] irq_msk_reg;
   logic [2:0]       step_reg;
   stc_hst_state_t   state_reg;
   logic             wr_en;
   logic             rd_en;
   logic             go;
   logic             finish;

   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && penable && !pwrite;
   assign go      = wr_en && paddr == A_CTRL && pwdata[0] && state_reg == HST_IDLE;
   assign finish  = state_reg == HST_WAIT && !tf.rd_status[ST_BSY];
   assign irq     = |(irq_st_reg & irq_msk_reg);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tf_addr_reg <= 32'h00000000;
         tf_cmd_reg  <= 24'h000000;
         irq_msk_reg <= '0;
      end else if (wr_en && state_reg == HST_IDLE) begin
         if (paddr == A_TF_ADDR) begin
            tf_addr_reg <= pwdata;
         end else if (paddr == A_TF_CMD) begin
            tf_cmd_reg <= pwdata[23:0];
         end else if (paddr == A_IRQ_MSK) begin
            irq_msk_reg <= pwdata[IRQ_W-1:0];
         end
      end else if (wr_en && paddr == A_IRQ_MSK) begin
         irq_msk_reg <= pwdata[IRQ_W-1:0];
      end
   end

   // ****************************************
   // task-file write sequence
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg   <= HST_IDLE;
         step_reg    <= TF_FEATURE;
         tf.tf_wr    <= 1'b0;
         tf.tf_addr  <= 3'h0;
         tf.tf_wdata <= 8'h00;
      end else begin
         tf.tf_wr <= 1'b0;
         case (state_reg)
            HST_IDLE: begin
               if (go) begin
                  state_reg <= HST_SEND;
                  step_reg  <= TF_FEATURE;
               end
            end
            HST_SEND: begin
               tf.tf_wr   <= 1'b1;
               tf.tf_addr <= step_reg;
               if (step_reg == TF_FEATURE) begin
                  tf.tf_wdata <= tf_cmd_reg[15:8];
               end else if (step_reg == TF_SCOUNT) begin
                  tf.tf_wdata <= tf_cmd_reg[23:16];
               end else if (step_reg == TF_SNUM) begin
                  tf.tf_wdata <= tf_addr_reg[7:0];
               end else if (step_reg == TF_CYL_LO) begin
                  tf.tf_wdata <= tf_addr_reg[15:8];
               end else if (step_reg == TF_CYL_HI) begin
                  tf.tf_wdata <= tf_addr_reg[23:16];
               end else if (step_reg == TF_DEVHEAD) begin
                  tf.tf_wdata <= tf_addr_reg[31:24];
               end else begin
                  tf.tf_wdata <= tf_cmd_reg[7:0];
               end
               if (step_reg == TF_COMMAND) begin
                  state_reg <= HST_WAIT;
               end
               step_reg <= step_reg + 3'h1;
            end
            HST_WAIT: begin
               // status of the previous command is stale for one cycle
               if (finish && !tf.tf_wr) begin
                  state_reg <= HST_IDLE;
               end
            end
            default: state_reg <= HST_IDLE;
         endcase
      end
   end

   // ****************************************
   // results and sticky events
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_reg <= 32'h00000000;
         res_sc_reg <= 8'h00;
         res_ef_reg <= 16'h0000;
         irq_st_reg <= '0;
      end else begin
         // clear only bits already reported, so a new event survives
         if (rd_en && paddr == A_IRQ_ST) begin
            irq_st_reg <= irq_st_reg & ~prdata[IRQ_W-1:0];
         end
         if (finish && !tf.tf_wr) begin
            result_reg <= {tf.rd_devhead, tf.rd_cyl_hi, tf.rd_cyl_lo, tf.rd_snum};
            res_sc_reg <= tf.rd_scount;
            res_ef_reg <= {tf.rd_error, tf.rd_status};
            irq_st_reg[IRQ_DONE] <= 1'b1;
            if (tf.rd_status[ST_ERR]) begin
               irq_st_reg[IRQ_FAIL] <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         if (paddr == A_TF_ADDR) begin
            prdata <= tf_addr_reg;
         end else if (paddr == A_TF_CMD) begin
            prdata <= {8'h00, tf_cmd_reg};
         end else if (paddr == A_STATE) begin
            prdata <= {15'h0000, state_reg != HST_IDLE, res_ef_reg};
         end else if (paddr == A_RESULT) begin
            prdata <= result_reg;
         end else if (paddr == A_RES_SC) begin
            prdata <= {24'h000000, res_sc_reg};
         end else if (paddr == A_IRQ_ST) begin
            prdata <= {30'h00000000, irq_st_reg};
         end else if (paddr == A_IRQ_MSK) begin
            prdata <= {30'h00000000, irq_msk_reg};
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end

endmodule
`default_nettype wire

// ===== tb/stc_taskfile_properties.sv
// assertions on the task-file link between the host and drive ends
// assumes one pclk domain; instantiated beside the interface
`timescale 1ns/1ps
`default_nettype none
module stc_taskfile_properties
   import stc_pkg::*;
(
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       tf_wr,
   input wire logic [2:0] tf_addr,
   input wire logic [7:0] tf_wdata,
   input wire logic [7:0] rd_error,
   input wire logic [7:0] rd_snum,
   input wire logic [7:0] rd_cyl_lo,
   input wire logic [7:0] rd_cyl_hi,
   input wire logic [7:0] rd_devhead,
   input wire logic [7:0] rd_status
);
   // ****************************************
   // copies of what the host last wrote
   // ****************************************
   logic [7:0] feat_reg, cmd_reg, snum_reg, lo_reg, hi_reg, dh_reg;
   logic       cmd_go;
   assign cmd_go = tf_wr && (tf_addr == TF_COMMAND) && !rd_status[ST_BSY];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         feat_reg <= 8'h00;
         cmd_reg  <= 8'h00;
         snum_reg <= 8'h00;
         lo_reg   <= 8'h00;
         hi_reg   <= 8'h00;
         dh_reg   <= 8'h00;
      end else if (tf_wr && !rd_status[ST_BSY]) begin
         case (tf_addr)
            TF_FEATURE: feat_reg <= tf_wdata;
            TF_SNUM:    snum_reg <= tf_wdata;
            TF_CYL_LO:  lo_reg <= tf_wdata;
            TF_CYL_HI:  hi_reg <= tf_wdata;
            TF_DEVHEAD: dh_reg <= tf_wdata;
            TF_COMMAND: cmd_reg <= tf_wdata;
            default: ;
         endcase
      end
   end

   // ****************************************
   // properties
   // ****************************************
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_cmd_busy: assert property (cmd_go |=> rd_status == 8'h80 && rd_error == 8'h00)
      else $error("command write did not raise busy");
   chk_sense_ok: assert property (cmd_go && tf_wdata == OP_SENSE && feat_reg == SENSE_FEAT
      |=> ##1 rd_status == 8'h50 && rd_error == 8'h00)
      else $error("sense did not complete cleanly");
   chk_sense_abort: assert property (cmd_go && tf_wdata == OP_SENSE && feat_reg != SENSE_FEAT
      |=> ##1 rd_status == 8'h51 && rd_error == 8'h04)
      else $error("bad feature sense not aborted");
   chk_seek_hold: assert property (cmd_go && tf_wdata[7:4] == OP_SEEK_NIB
      |=> rd_status[ST_BSY] [*2])
      else $error("seek dropped busy early");
   chk_seek_finish: assert property (cmd_go && tf_wdata[7:4] == OP_SEEK_NIB
      |=> ##[2:100] !rd_status[ST_BSY])
      else $error("seek never finished");
   chk_done_flags: assert property ($fell(rd_status[ST_BSY])
      |-> rd_status[ST_RDY] && rd_status[ST_DSC])
      else $error("ready or seek complete missing at end");
   chk_error_bits: assert property (rd_status[ST_ERR] |-> rd_error inside {8'h04, 8'h10})
      else $error("error register holds other bits");
   chk_lba_report: assert property ($fell(rd_status[ST_BSY]) && cmd_reg[7:4] == OP_SEEK_NIB
      && dh_reg[DH_LBA_BIT] && !rd_status[ST_ERR]
      |-> {rd_devhead[3:0], rd_cyl_hi, rd_cyl_lo, rd_snum} == {dh_reg[3:0], hi_reg, lo_reg, snum_reg})
      else $error("lba position not reported");

   cov_sense: cover property (cmd_go && tf_wdata == OP_SENSE);
   cov_lba_seek: cover property ($fell(rd_status[ST_BSY]) && dh_reg[DH_LBA_BIT]);
   cov_idnf: cover property (rd_status[ST_ERR] && rd_error == 8'h10);
endmodule
`default_nettype wire

// ===== tb/seek_and_temp_sense_cmds_bench.sv
// top bench: apb stimulus into the host end, drive end across the link
// assumes a 200 MHz pclk and a bench actuator answering seek requests
`timescale 1ns/1ps
`default_nettype none
module seek_and_temp_sense_cmds_bench;
   import stc_pkg::*;
   logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic        [7:0]  paddr;
   logic        [31:0] pwdata, prdata, rd, st, res, sc;
   logic               standby, seek_req, seek_lba_mode, seek_done, seek_idnf, seek_abort;
   logic signed [9:0]  temp_half_c;
   logic        [15:0] seek_cyl, got_cyl;
   logic        [3:0]  seek_head, got_head;
   logic        [27:0] seek_lba, got_lba;
   logic               got_mode;
   logic        [4:0]  dly_cnt;
   int                 n_fail, tests_run, k;
   logic signed [9:0]  temps [7] = '{-10'sd41, -10'sd40, -10'sd39, 10'sd0, 10'sd213, 10'sd214, 10'sd215};
   logic        [7:0]  codes [7] = '{8'h00, 8'h00, 8'h01, 8'h28, 8'hfd, 8'hfe, 8'hff};
   logic        [7:0]  feats [3] = '{8'h00, 8'h02, 8'hff};

   stc_taskfile_if tf_link ();
   stc_host_ctrl stc_host_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .tf(tf_link));
   stc_drive_cmd stc_drive_cmd_inst (.pclk(pclk), .presetn(presetn), .tf(tf_link),
      .standby(standby), .temp_half_c(temp_half_c), .seek_req(seek_req),
      .seek_lba_mode(seek_lba_mode), .seek_cyl(seek_cyl), .seek_head(seek_head),
      .seek_lba(seek_lba), .seek_done(seek_done), .seek_idnf(seek_idnf), .seek_abort(seek_abort));
   stc_taskfile_properties stc_taskfile_properties_inst (.pclk(pclk), .presetn(presetn),
      .tf_wr(tf_link.tf_wr), .tf_addr(tf_link.tf_addr), .tf_wdata(tf_link.tf_wdata),
      .rd_error(tf_link.rd_error), .rd_snum(tf_link.rd_snum), .rd_cyl_lo(tf_link.rd_cyl_lo),
      .rd_cyl_hi(tf_link.rd_cyl_hi), .rd_devhead(tf_link.rd_devhead),
      .rd_status(tf_link.rd_status));

   // ****************************************
   // clock and slow actuator
   // ****************************************
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seek_done <= 1'b0;
         dly_cnt   <= 5'd0;
      end else begin
         seek_done <= 1'b0;
         if (seek_req === 1'b1) begin
            dly_cnt  <= 5'd20;
            got_mode <= seek_lba_mode;
            got_cyl  <= seek_cyl;
            got_head <= seek_head;
            got_lba  <= seek_lba;
         end else if (dly_cnt != 5'd0) begin
            dly_cnt   <= dly_cnt - 5'd1;
            seek_done <= (dly_cnt == 5'd1);
         end
      end
   end

   // ****************************************
   // tasks
   // ****************************************
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int i;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 64);
      if (i >= 64) begin
         n_fail++;
         summarize();
      end
      q = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic run(input logic [31:0] tfa, input logic [31:0] tfc);
      int i;
      apb(1'b1, A_TF_ADDR, tfa, rd);
      apb(1'b1, A_TF_CMD, tfc, rd);
      apb(1'b1, A_CTRL, 32'h1, rd);
      i = 0;
      do begin
         apb(1'b0, A_STATE, 32'h0, st);
         i++;
      end while (st[16] !== 1'b0 && i < 100);
      if (i >= 100) begin
         n_fail++;
         summarize();
      end
      apb(1'b0, A_RESULT, 32'h0, res);
      apb(1'b0, A_RES_SC, 32'h0, sc);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {standby, seek_idnf, seek_abort} = '0;
      temp_half_c = 10'sd0;
      n_fail = 0;
      tests_run = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h40, 32'h0, rd);
      check("unmapped read", rd, 32'h0);
      apb(1'b1, A_IRQ_MSK, 32'h1, rd);
      for (k = 0; k < 7; k++) begin
         temp_half_c <= temps[k];
         standby <= k[0];
         run(32'h0, {16'h0, SENSE_FEAT, OP_SENSE});
         check("sense code", {24'h0, sc[7:0]}, {24'h0, codes[k]});
         check("sense state", {16'h0, st[15:0]}, 32'h0050);
         if (k == 0) begin
            check("irq raised", {31'h0, irq}, 32'h1);
            apb(1'b0, A_IRQ_ST, 32'h0, rd);
            check("irq status", {30'h0, rd[1:0]}, 32'h1);
            @(negedge pclk);
            check("irq cleared", {31'h0, irq}, 32'h0);
            apb(1'b1, A_IRQ_MSK, 32'h0, rd);
         end
      end
      apb(1'b0, A_IRQ_ST, 32'h0, rd);
      for (k = 0; k < 3; k++) begin
         run(32'h0, {16'h0, feats[k], OP_SENSE});
         check("sense abort", {16'h0, st[15:0]}, 32'h0451);
      end
      check("irq masked", {31'h0, irq}, 32'h0);
      apb(1'b0, A_IRQ_ST, 32'h0, rd);
      check("fail event", {31'h0, rd[IRQ_FAIL]}, 32'h1);
      run(32'he5abcd12, 32'h7a);
      check("lba target", {4'h0, got_lba}, 32'h05abcd12);
      check("lba mode", {31'h0, got_mode}, 32'h1);
      check("lba report", {4'h0, res[27:0]}, 32'h05abcd12);
      check("seek state", {16'h0, st[15:0]}, 32'h0050);
      run(32'ha3123499, 32'h70);
      check("chs target", {11'h0, got_mode, got_head, got_cyl}, 32'h31234);
      seek_idnf <= 1'b1;
      run(32'ha3123499, 32'h75);
      check("seek idnf", {16'h0, st[15:0]}, 32'h1051);
      seek_idnf  <= 1'b0;
      seek_abort <= 1'b1;
      run(32'he0000001, 32'h7f);
      check("seek abort", {16'h0, st[15:0]}, 32'h0451);
      seek_abort <= 1'b0;
      run(32'h0, 32'h000000e5);
      check("unknown op", {16'h0, st[15:0]}, 32'h0451);
      summarize();
   end
endmodule
`default_nettype wire
